//--- core/cmc_defs.svh
/*
  Constants of the configuration memory CRC checker: widths, CRC
  parameters, reset values and cycle counts.
  Assumes inclusion by bare name from the package and the checker.
*/
`ifndef CMC_DEFS_SVH
`define CMC_DEFS_SVH

// Byte address of the configuration readback port
`define CMC_ADDR_W        17
`define CMC_ADDR_ZERO     17'h00000
`define CMC_ADDR_ONE      17'h00001
`define CMC_CFG_BYTES_DEF 17'h01000

// Reflected 32-bit CRC, all-ones seed and final inversion
`define CMC_CRC_POLY      32'hedb88320
`define CMC_CRC_INIT      32'hffffffff
`define CMC_CRC_XOROUT    32'hffffffff
`define CMC_EXP_CRC_RST   32'h00000000

// Checker clock: run rate, ceiling and floor, in kHz
`define CMC_CLK_KHZ       10000
`define CMC_CLK_MAX_KHZ   33250
`define CMC_CLK_MIN_KHZ   2080

// Abort hand-back wait and least reconfiguration pin low time, in cycles
`define CMC_ABORT_WAIT    2'h2
`define CMC_WAIT_ONE      2'h1
`define CMC_WAIT_ZERO     2'h0
`define CMC_PIN_LOW_MIN   3'h6
`define CMC_PIN_LOW_MAX   3'h7
`define CMC_CNT_ONE       3'h1
`define CMC_CNT_ZERO      3'h0

`endif

//--- core/cmc_pkg.sv
/*
  Types shared by the configuration memory CRC checker files.
  Assumes cmc_defs.svh is on the include path.
*/
`default_nettype none
`include "cmc_defs.svh"

package cmc_pkg;

  // Readback byte address
  typedef logic [`CMC_ADDR_W-1:0] cmc_addr_type;

  // Check sequencer
  typedef enum logic [1:0] {
    CMC_IDLE   = 2'b00,
    CMC_RUN    = 2'b01,
    CMC_FINISH = 2'b10,
    CMC_WAIT   = 2'b11
  } cmc_state_type;

endpackage : cmc_pkg

`default_nettype wire

//--- core/cmc_sync.sv
/*
  Two-stage synchroniser for a group of asynchronous pin levels.
  Assumes a synchronous active-low reset on the destination clock.
*/
`default_nettype none

module cmc_sync #(
  parameter int       W       = 1,
  parameter bit       RST_VAL = 1'b1
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_dout;

  // First stage is read only by the second stage
  always_comb begin
    next_meta = rst_n ? din  : {W{RST_VAL}};
    next_dout = rst_n ? meta : {W{RST_VAL}};
  end

  always_ff @(posedge clk_sys) begin
    meta <= next_meta;
    dout <= next_dout;
  end

endmodule : cmc_sync

`default_nettype wire

//--- core/cmc_crc_byte.sv
/*
  One-byte update of the reflected 32-bit CRC, LSB first.
  Assumes the caller seeds and inverts the running value.
*/
`default_nettype none
`include "cmc_defs.svh"

module cmc_crc_byte (
  input  wire logic [31:0] crc_in,
  input  wire logic [7:0]  data,
  output logic      [31:0] crc_out
);

  logic [31:0] stage [0:8];

  assign stage[0] = crc_in;

  // One shift per data bit, unrolled so a byte folds in one cycle
  for (genvar i = 0; i < 8; i++) begin : g_bit
    assign stage[i+1] = (stage[i][0] ^ data[i]) ?
                        ((stage[i] >> 1) ^ `CMC_CRC_POLY) : (stage[i] >> 1);
  end

  assign crc_out = stage[8];

endmodule : cmc_crc_byte

`default_nettype wire

//--- core/cmc_checker.sv
/*
  Configuration memory CRC checker: sequencer, byte readback, CRC
  compare, abort on configuration access, reconfiguration pin filter.
  Assumes a readback memory with combinational byte read and fabric
  control inputs clocked by gated_check_clock_out.
*/
`default_nettype none
`include "cmc_defs.svh"

module cmc_checker #(
  parameter cmc_pkg::cmc_addr_type CFG_BYTES = `CMC_CFG_BYTES_DEF
) (
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  input  wire logic                  check_enable,
  input  wire logic                  check_start,
  input  wire logic                  force_error,
  input  wire logic                  standby_disable,
  input  wire logic                  oneshot_mode,
  input  wire logic                  config_done,
  input  wire logic                  expected_crc_load,
  input  wire logic [31:0]           expected_crc_value,
  output cmc_pkg::cmc_addr_type      rd_addr,
  input  wire logic [7:0]            rd_data,
  input  wire logic                  rd_excluded,
  input  wire logic                  refresh_command,
  input  wire logic                  config_enable_command,
  input  wire logic                  config_enable_exclusive_command,
  input  wire logic                  config_disable_command,
  input  wire logic                  ieee1532_instruction,
  input  wire logic                  i2c_address_match,
  input  wire logic                  spi_chip_select_n,
  input  wire logic                  reconfig_request_pin_n,
  output logic                       config_access_ready,
  output logic                       reconfig_detected,
  output logic                       gated_check_clock_out,
  output logic                       check_done,
  output logic                       check_in_progress,
  output logic                       crc_error_flag
);
  import cmc_pkg::*;

  cmc_state_type state;
  cmc_state_type next_state;
  cmc_addr_type  next_rd_addr;
  logic [31:0]   crc;
  logic [31:0]   next_crc;
  logic [31:0]   crc_step;
  logic [31:0]   expected_crc;
  logic [31:0]   next_expected_crc;
  logic [1:0]    wait_cnt;
  logic [1:0]    next_wait_cnt;
  logic          force_seen;
  logic          next_force_seen;
  logic          start_q;
  logic          force_q;
  logic          oneshot_pend;
  logic          next_oneshot_pend;
  logic          next_done;
  logic          next_in_prog;
  logic          next_error;
  logic          start_rise;
  logic          force_rise;
  logic          go;
  logic          access_any;
  logic          enabled;
  logic          spi_cs_n_s;
  logic          pin_n_s;
  logic [2:0]    pin_low_cnt;
  logic [2:0]    next_pin_low_cnt;
  logic          next_reconfig_detected;
  logic          en_low_phase;
  logic [31:0]   crc_final;
  logic          hlp_force;
  logic          next_hlp_force;

  // Pins from outside the clock domain
  cmc_sync #(.W(2), .RST_VAL(1'b1)) u_pin_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .din     ({spi_chip_select_n, reconfig_request_pin_n}),
    .dout    ({spi_cs_n_s, pin_n_s})
  );

  cmc_crc_byte u_crc (
    .crc_in  (crc),
    .data    (rd_data),
    .crc_out (crc_step)
  );

  // Enable sampled on the falling edge so the gate never chops a high phase
  always_ff @(negedge clk_sys) begin
    en_low_phase <= rst_n & check_enable;
  end
  assign gated_check_clock_out = clk_sys & en_low_phase;

  // Events and conditions
  assign start_rise = check_start & ~start_q;
  assign force_rise = force_error & ~force_q;
  assign enabled    = check_enable & ~standby_disable;
  assign access_any = refresh_command | config_enable_command
                    | config_enable_exclusive_command
                    | config_disable_command | ieee1532_instruction
                    | ~spi_cs_n_s
                    | i2c_address_match;
  assign go = enabled & (oneshot_mode ? oneshot_pend : start_rise);
  assign crc_final = crc ^ `CMC_CRC_XOROUT;
  assign config_access_ready = (state == CMC_IDLE);

  // Sequencer next values
  always_comb begin
    next_state        = state;
    next_rd_addr      = rd_addr;
    next_crc          = crc;
    next_wait_cnt     = wait_cnt;
    next_force_seen   = force_seen;
    next_done         = check_done;
    next_in_prog      = check_in_progress;
    next_error        = crc_error_flag;
    next_expected_crc = expected_crc_load ? expected_crc_value : expected_crc;
    // Set wins over the clear taken by a starting check
    next_oneshot_pend = (oneshot_pend & ~(go & oneshot_mode))
                      | (config_done & oneshot_mode);
    unique case (state)
      CMC_IDLE: begin
        if (!oneshot_mode && !check_start) begin
          next_done = 1'b0;
        end
        if (go) begin
          next_state      = CMC_RUN;
          next_rd_addr    = `CMC_ADDR_ZERO;
          next_crc        = `CMC_CRC_INIT;
          next_force_seen = 1'b0;
          next_done       = 1'b0;
          next_error      = 1'b0;
          next_in_prog    = 1'b1;
        end
      end
      CMC_RUN: begin
        if (!enabled) begin
          next_state   = CMC_IDLE;
          next_in_prog = 1'b0;
        end else if (access_any) begin
          next_state    = CMC_WAIT;
          next_wait_cnt = `CMC_WAIT_ZERO;
          next_in_prog  = 1'b0;
        end else if (!oneshot_mode && !check_start) begin
          next_state   = CMC_IDLE;
          next_in_prog = 1'b0;
        end else begin
          if (!rd_excluded) begin
            next_crc = crc_step;
          end
          next_force_seen = force_seen | (force_rise & ~oneshot_mode);
          next_rd_addr    = rd_addr + `CMC_ADDR_ONE;
          if (rd_addr == CFG_BYTES - `CMC_ADDR_ONE) begin
            next_state = CMC_FINISH;
          end
        end
      end
      CMC_FINISH: begin
        next_state   = CMC_IDLE;
        next_error   = (crc_final != expected_crc) | force_seen;
        next_done    = 1'b1;
        next_in_prog = 1'b0;
      end
      CMC_WAIT: begin
        // Two checker cycles while the clock moves back to configuration
        next_wait_cnt = wait_cnt + `CMC_WAIT_ONE;
        if (wait_cnt == `CMC_ABORT_WAIT - `CMC_WAIT_ONE) begin
          next_state = CMC_IDLE;
        end
      end
    endcase
  end

  // Reconfiguration pin low filter; detection needs a seventh low cycle
  always_comb begin
    next_pin_low_cnt       = `CMC_CNT_ZERO;
    next_reconfig_detected = 1'b0;
    if (!pin_n_s) begin
      next_reconfig_detected = (pin_low_cnt == `CMC_PIN_LOW_MIN);
      next_pin_low_cnt = (pin_low_cnt == `CMC_PIN_LOW_MAX) ?
                         pin_low_cnt : pin_low_cnt + `CMC_CNT_ONE;
    end
  end

  // Register all state except en_low_phase and hlp_force
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state             <= CMC_IDLE;
      rd_addr           <= `CMC_ADDR_ZERO;
      crc               <= `CMC_CRC_INIT;
      expected_crc      <= `CMC_EXP_CRC_RST;
      wait_cnt          <= `CMC_WAIT_ZERO;
      force_seen        <= 1'b0;
      start_q           <= 1'b0;
      force_q           <= 1'b0;
      oneshot_pend      <= 1'b0;
      check_done        <= 1'b0;
      check_in_progress <= 1'b0;
      crc_error_flag    <= 1'b0;
      pin_low_cnt       <= `CMC_CNT_ZERO;
      reconfig_detected <= 1'b0;
    end else begin
      state             <= next_state;
      rd_addr           <= next_rd_addr;
      crc               <= next_crc;
      expected_crc      <= next_expected_crc;
      wait_cnt          <= next_wait_cnt;
      force_seen        <= next_force_seen;
      start_q           <= check_start;
      force_q           <= force_error;
      oneshot_pend      <= next_oneshot_pend;
      check_done        <= next_done;
      check_in_progress <= next_in_prog;
      crc_error_flag    <= next_error;
      pin_low_cnt       <= next_pin_low_cnt;
      reconfig_detected <= next_reconfig_detected;
    end
  end

  // Assertion helper: a force edge taken in this pass, cleared in idle
  always_comb begin
    next_hlp_force = hlp_force;
    if (state == CMC_IDLE) begin
      next_hlp_force = 1'b0;
    end else if (state == CMC_RUN && enabled && !access_any && check_start
                 && !oneshot_mode && force_rise) begin
      next_hlp_force = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      hlp_force <= 1'b0;
    end else begin
      hlp_force <= next_hlp_force;
    end
  end

  // Checks on the sequencer and its outputs
  default clocking cb_main @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  AST_ABORT_OUTPUTS: assert property (
    state == CMC_RUN && enabled && access_any
    |=> !check_in_progress && !check_done && !crc_error_flag
  ) else $error("abort left a status output high");

  AST_ABORT_WAIT: assert property (
    state == CMC_RUN && enabled && access_any
    |=> !config_access_ready [*2] ##1 config_access_ready
  ) else $error("access not held off exactly two cycles");

  AST_START: assert property (
    state == CMC_IDLE && !oneshot_mode && enabled && start_rise
    |=> check_in_progress && !check_done && !crc_error_flag
  ) else $error("start edge did not begin a check");

  AST_DISABLE: assert property (
    !check_enable || standby_disable |=> !check_in_progress
  ) else $error("check kept running while disabled");

  AST_MISMATCH: assert property (
    state == CMC_FINISH && crc_final != expected_crc
    |=> crc_error_flag && check_done && !check_in_progress
  ) else $error("crc mismatch not reported");

  AST_FORCE: assert property (
    state == CMC_FINISH && hlp_force |=> crc_error_flag
  ) else $error("forced error not reported");

  AST_BYTE_STEP: assert property (
    state == CMC_RUN && $past(state) == CMC_RUN
    |-> rd_addr == $past(rd_addr) + `CMC_ADDR_ONE
  ) else $error("readback address did not advance by one byte");

  AST_EXCLUDED: assert property (
    state == CMC_RUN && rd_excluded |=> crc == $past(crc)
  ) else $error("excluded byte changed the crc");

  AST_RECONFIG: assert property (
    reconfig_detected |-> $past(!pin_n_s) && $past(!pin_n_s, 7)
  ) else $error("reconfiguration seen on a short low pulse");

  AST_ONESHOT: assert property (
    state == CMC_IDLE && oneshot_mode && oneshot_pend && enabled
    |=> check_in_progress ##1 !oneshot_pend || config_done
  ) else $error("one-shot check not launched");

  COV_PASS:  cover property (state == CMC_FINISH ##1 check_done && !crc_error_flag);
  COV_ERR:   cover property (state == CMC_FINISH ##1 crc_error_flag);
  COV_ABORT: cover property (state == CMC_WAIT ##1 state == CMC_WAIT ##1 state == CMC_IDLE);

endmodule : cmc_checker

`default_nettype wire

//--- tb/cmc_mem_model.sv
/*
  Readback memory model standing in front of the checker: one byte per
  address, combinational, with every fourth byte flagged as block RAM.
  Assumes the checker registers rd_addr and samples in the same cycle.
*/
`default_nettype none
`include "cmc_defs.svh"

module cmc_mem_model (
  input  wire logic [`CMC_ADDR_W-1:0] rd_addr,
  output logic      [7:0]             rd_data,
  output logic                        rd_excluded
);
  timeunit 1ns;
  timeprecision 1ns;

  // Cheap address-derived pattern, no storage needed
  assign rd_data     = rd_addr[7:0] ^ 8'hc3;
  // Excluded bytes carry live data, so folding them in shows up
  assign rd_excluded = (rd_addr[1:0] == 2'h3);
endmodule : cmc_mem_model

`default_nettype wire

//--- tb/cmc_checker_tb_top.sv
/*
  Self-checking bench of the configuration memory CRC checker.
  Assumes cmc_defs.svh on the include path and a short pass length.
*/
`default_nettype none
`include "cmc_defs.svh"

`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end

module cmc_checker_tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int CFG = 8;
  logic                    clk_sys = 1'b0;
  logic                    rst_n   = 1'b0;
  logic                    en      = 1'b1;
  logic                    start   = 1'b0;
  logic                    frc     = 1'b0;
  logic                    stby    = 1'b0;
  logic                    osm     = 1'b0;
  logic                    cdone   = 1'b0;
  logic                    ld      = 1'b0;
  logic                    pin_n   = 1'b1;
  logic [31:0]             expv    = 32'h00000000;
  logic [6:0]              acc     = 7'h00;
  wire logic [`CMC_ADDR_W-1:0] rd_addr;
  wire logic [7:0]         rd_data;
  wire logic               rd_excl, ready, recfg, gclk, done, inprog, err;
  int                      n_mismatch = 0;
  int                      num_checks = 0;
  realtime                 t_edge;

  // 10 MHz checker clock
  always #50 clk_sys = ~clk_sys;

  cmc_checker #(.CFG_BYTES(17'h00008)) i_cmc_checker (
    .clk_sys(clk_sys), .rst_n(rst_n), .check_enable(en), .check_start(start),
    .force_error(frc), .standby_disable(stby), .oneshot_mode(osm),
    .config_done(cdone), .expected_crc_load(ld), .expected_crc_value(expv),
    .rd_addr(rd_addr), .rd_data(rd_data), .rd_excluded(rd_excl),
    .refresh_command(acc[0]), .config_enable_command(acc[1]),
    .config_enable_exclusive_command(acc[2]), .config_disable_command(acc[3]),
    .ieee1532_instruction(acc[4]), .i2c_address_match(acc[5]),
    .spi_chip_select_n(~acc[6]), .reconfig_request_pin_n(pin_n),
    .config_access_ready(ready), .reconfig_detected(recfg),
    .gated_check_clock_out(gclk), .check_done(done),
    .check_in_progress(inprog), .crc_error_flag(err));

  cmc_mem_model i_cmc_mem_model (
    .rd_addr(rd_addr), .rd_data(rd_data), .rd_excluded(rd_excl));

  task automatic results();
    if (n_mismatch == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results

  // Reference CRC over the model's pattern, excluded bytes skipped
  function automatic logic [31:0] crc_exp();
    logic [31:0] c;
    logic [7:0]  d;
    c = `CMC_CRC_INIT;
    for (int a = 0; a < CFG; a++) begin
      if (a[1:0] != 2'h3) begin
        d = a[7:0] ^ 8'hc3;
        for (int i = 0; i < 8; i++) c = (c[0] ^ d[i]) ? (c >> 1) ^ `CMC_CRC_POLY : c >> 1;
      end
    end
    return c ^ `CMC_CRC_XOROUT;
  endfunction : crc_exp

  // Bounded wait on in-progress; a hang ends the run
  task automatic wait_prog(input logic v);
    int k;
    k = 0;
    while (inprog !== v) begin
      @(posedge clk_sys);
      #1;
      k++;
      if (k > 200) begin
        $display("MISMATCH wait_prog exp %0h got timeout", v);
        n_mismatch++;
        results();
      end
    end
  endtask : wait_prog

  // Full pass, optional forced error
  task automatic t_pass(input logic [31:0] crc, input logic f, input logic e);
    int n;
    @(posedge clk_sys);
    ld   <= 1'b1;
    expv <= crc;
    @(posedge clk_sys);
    ld    <= 1'b0;
    start <= 1'b1;
    wait_prog(1'b1);
    `CHK("ready_run", 1'b0, ready);
    n = 0;
    while (inprog === 1'b1 && n < 100) begin
      n++;
      @(posedge clk_sys);
      if (n == 3) frc <= f;
      #1;
    end
    `CHK("run_len", CFG + 1, n);
    `CHK("done", 1'b1, done);
    `CHK("err", e, err);
    @(posedge clk_sys);
    start <= 1'b0;
    frc   <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    `CHK("done_clr", 1'b0, done);
  endtask : t_pass

  // Access during a run; count the hand-back wait
  task automatic t_abort(input int b);
    int w;
    @(posedge clk_sys);
    start <= 1'b1;
    wait_prog(1'b1);
    @(posedge clk_sys);
    acc[b] <= 1'b1;
    w = 0;
    for (int k = 0; k < 12 && ready !== 1'b1; k++) begin
      @(posedge clk_sys);
      #1;
      if (inprog === 1'b0 && ready === 1'b0) w++;
    end
    `CHK("abort_wait", 2, w);
    `CHK("abort_done", 1'b0, done);
    `CHK("abort_err", 1'b0, err);
    @(posedge clk_sys);
    start <= 1'b0;
    acc   <= 7'h00;
    repeat (2) @(posedge clk_sys);
  endtask : t_abort

  // Stop a run: 0 enable low, 1 standby, 2 start low
  task automatic t_stop(input int m);
    wait_prog(1'b0);
    @(posedge clk_sys);
    start <= 1'b1;
    wait_prog(1'b1);
    #25;
    `CHK("gclk_on", 1'b1, gclk);
    @(posedge clk_sys);
    en    <= (m != 0);
    stby  <= (m == 1);
    start <= (m != 2);
    repeat (3) @(posedge clk_sys);
    #1;
    `CHK("stop_prog", 1'b0, inprog);
    `CHK("stop_done", 1'b0, done);
    #25;
    if (m == 0) `CHK("gclk_off", 1'b0, gclk);
    @(posedge clk_sys);
    en    <= 1'b1;
    stby  <= 1'b0;
    start <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask : t_stop

  // One automatic pass after configuration, no second one
  task automatic t_oneshot();
    int n;
    @(posedge clk_sys);
    osm   <= 1'b1;
    cdone <= 1'b1;
    @(posedge clk_sys);
    cdone <= 1'b0;
    wait_prog(1'b1);
    wait_prog(1'b0);
    `CHK("os_done", 1'b1, done);
    `CHK("os_err", 1'b0, err);
    // Any in-progress cycle here would be a second pass
    n = 0;
    repeat (30) begin
      @(posedge clk_sys);
      #1;
      if (inprog !== 1'b0) n++;
    end
    `CHK("os_once", 0, n);
    @(posedge clk_sys);
    osm <= 1'b0;
  endtask : t_oneshot

  // Pin low six cycles is too short, twelve is enough
  // Detection is a one-cycle pulse, so every cycle is watched
  task automatic t_reconfig();
    int seen;
    seen = 0;
    @(posedge clk_sys);
    pin_n <= 1'b0;
    for (int k = 0; k < 11; k++) begin
      @(posedge clk_sys);
      if (k == 5) pin_n <= 1'b1;
      #1;
      if (recfg === 1'b1) seen++;
    end
    `CHK("pin_short", 0, seen);
    @(posedge clk_sys);
    pin_n <= 1'b0;
    seen = 0;
    repeat (12) begin
      @(posedge clk_sys);
      #1;
      if (recfg === 1'b1) seen++;
    end
    `CHK("pin_long", 1, seen);
    @(posedge clk_sys);
    pin_n <= 1'b1;
  endtask : t_reconfig

  // Main sequence
  initial begin
    // Clock period measured during reset against the allowed range
    @(posedge clk_sys);
    t_edge = $realtime;
    @(posedge clk_sys);
    `CHK("clk_max", 1'b1, ($realtime - t_edge) * `CMC_CLK_MAX_KHZ >= 1.0e6);
    `CHK("clk_range", 1'b1, ($realtime - t_edge) * `CMC_CLK_MIN_KHZ <= 1.0e6);
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1;
    `CHK("rst_ready", 1'b1, ready);
    `CHK("rst_prog", 1'b0, inprog);
    t_pass(crc_exp(), 1'b0, 1'b0);
    t_pass(crc_exp() ^ 32'h00000001, 1'b0, 1'b1);
    t_pass(crc_exp(), 1'b1, 1'b1);
    for (int b = 0; b < 7; b++) t_abort(b);
    for (int m = 0; m < 3; m++) t_stop(m);
    t_oneshot();
    t_reconfig();
    results();
  end
endmodule : cmc_checker_tb_top

`default_nettype wire
